/* File: shared/aic_pkg.sv */
/*
 Constants for the converter interface and configuration registers.
 Assumes a register port driven by the serial interface decoder.
*/
package aic_pkg;
    localparam int          REG_AW              = 8;
    localparam int          REG_DW              = 16;
    localparam logic [7:0]  SER_IF_CTRL_ADDR    = 8'h02;
    localparam logic [7:0]  CONV_CFG_ADDR       = 8'h03;
    localparam logic [15:0] SER_IF_CTRL_RESET   = 16'h0000;
    localparam logic [15:0] CONV_CFG_RESET      = 16'h1340;
    localparam logic [15:0] SER_IF_CTRL_MASK    = 16'h004d;
    localparam logic [15:0] CONV_CFG_MASK       = 16'h1f7f;
    localparam int          SHORT_WORD_BIT      = 0;
    localparam int          CHK_LSB             = 2;
    localparam int          STATUS_APPEND_BIT   = 6;
    localparam int          CHAN_EN_LSB         = 0;
    localparam int          INPUT_BUF_LSB       = 8;
    localparam int          REF_BUF_LSB         = 10;
    localparam int          OUTPUT_CODING_BIT   = 12;
    localparam int          RESULT_W            = 24;
    localparam int          SHORT_W             = 16;
    localparam int          STATUS_W            = 8;
    localparam int          READ_W              = 32;
    localparam logic [3:0]  CHAN_DEFAULT        = 4'h1;
    typedef enum logic [1:0] {
        AIC_CHK_OFF     = 2'h0,
        AIC_CHK_XOR_RD  = 2'h1,
        AIC_CHK_CRC_ALL = 2'h2,
        AIC_CHK_RSVD    = 2'h3
    } aic_chk_e;
endpackage

/* File: hdl/aic_regs.sv */
/*
 Interface control and converter configuration register bank.
 Assumes i_wr/i_rd are same-clock strobes from the serial decoder and the
 converter core presents results with a one-cycle done pulse.
*/
`timescale 1ns/1ps
// What this block does
// - The checksum field selects off, XOR-read/CRC-write, CRC both, reserved.
// - An active checksum adds one byte to every serial register transfer.
// - With status append set, a result read is followed by the status byte.
// - The appended status belongs to the same result as the data.
// - Results are 24 bits, or rounded to 16 with the short word length bit.
// - Writes never restart the converter; a new word length applies to next result, status append at once.
// - Output coding bit picks unipolar 0 or bipolar 1 and resets to 1.
// - Reference buffer field picks none, negative, positive or both.
// - Reset values are 0x0000 and 0x1340.
// - Result reads are 24 bits (16 short), or 32 (24 short) with status appended.
// - All channel enables clear means high voltage channel 0 is enabled.
module aic_regs (
    input  wire logic                 i_clock,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire logic [7:0]           i_addr,
    input  wire logic [15:0]          i_wdata,
    input  wire logic                 i_conv_done,
    input  wire logic [23:0]          i_conv_data,
    input  wire logic [7:0]           i_conv_status,
    input  wire logic                 i_result_rd,
    output logic      [15:0]          o_rdata,
    output logic      [31:0]          o_result,
    output logic      [5:0]           o_result_len,
    output logic      [1:0]           o_chk_mode,
    output logic                      o_chk_extra_byte,
    output logic                      o_bipolar,
    output logic      [1:0]           o_ref_buf,
    output logic      [1:0]           o_in_buf,
    output logic      [3:0]           o_chan_en
);
    logic [15:0] ifc_r;
    logic [15:0] cfg_r;
    logic [15:0] ifc_nxt;
    logic [15:0] cfg_nxt;
    logic [15:0] rdata_nxt;
    logic [23:0] data_r;
    logic [23:0] data_nxt;
    logic [7:0]  stat_r;
    logic        short_r;
    logic        capture;
    logic        ifc_wr;
    logic        cfg_wr;
    logic [1:0]  chk_field;
    logic [3:0]  chan_field;

    // Address match, shared by write and read decode
    function automatic logic addr_is(
        input logic [7:0] a,
        input logic [7:0] target
    );
        addr_is = (a == target);
    endfunction

    // Round half up; saturate so full scale never wraps to zero
    function automatic logic [23:0] round16(input logic [23:0] v);
        logic [16:0] s;
        s = {1'b0, v[23:8]} + {16'h0000, v[7]};
        if (s[16])
            round16 = 24'hffff00;
        else
            round16 = {s[15:0], 8'h00};
    endfunction

    // Codes 01 and 10 add a byte; reserved 11 is treated as off
    function automatic logic chk_adds_byte(input logic [1:0] m);
        chk_adds_byte = (m == aic_pkg::AIC_CHK_XOR_RD) ||
                        (m == aic_pkg::AIC_CHK_CRC_ALL);
    endfunction

    // Bit count of one result read
    function automatic logic [5:0] result_bits(
        input logic is_short,
        input logic with_stat
    );
        logic [5:0] n;
        n = is_short ? 6'(aic_pkg::SHORT_W) : 6'(aic_pkg::RESULT_W);
        if (with_stat)
            n = n + 6'(aic_pkg::STATUS_W);
        result_bits = n;
    endfunction

    always_comb begin
        ifc_nxt = i_wdata & aic_pkg::SER_IF_CTRL_MASK;
        cfg_nxt = i_wdata & aic_pkg::CONV_CFG_MASK;
    end

    always_comb begin
        ifc_wr = i_wr && addr_is(i_addr, aic_pkg::SER_IF_CTRL_ADDR);
        cfg_wr = i_wr && addr_is(i_addr, aic_pkg::CONV_CFG_ADDR);
    end

    always_comb begin
        if (addr_is(i_addr, aic_pkg::SER_IF_CTRL_ADDR))
            rdata_nxt = ifc_r;
        else if (addr_is(i_addr, aic_pkg::CONV_CFG_ADDR))
            rdata_nxt = cfg_r;
        else
            rdata_nxt = 16'h0000;
    end

    // A result under read is never overwritten; the new one is lost
    always_comb begin
        capture = i_conv_done && !i_result_rd;
        if (ifc_r[aic_pkg::SHORT_WORD_BIT])
            data_nxt = round16(i_conv_data);
        else
            data_nxt = i_conv_data;
    end

    always_comb begin
        chk_field  = ifc_r[aic_pkg::CHK_LSB +: 2];
        chan_field = cfg_r[aic_pkg::CHAN_EN_LSB +: 4];
    end

    // No converter restart path exists
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            ifc_r <= aic_pkg::SER_IF_CTRL_RESET;
        else if (ifc_wr)
            ifc_r <= ifc_nxt;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            cfg_r <= aic_pkg::CONV_CFG_RESET;
        else if (cfg_wr)
            cfg_r <= cfg_nxt;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_rdata <= 16'h0000;
        else if (i_rd)
            o_rdata <= rdata_nxt;
    end

    // Data and status captured together so channel bits match
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_r  <= 24'h000000;
            stat_r  <= 8'h00;
            short_r <= 1'b0;
        end else if (capture) begin
            short_r <= ifc_r[aic_pkg::SHORT_WORD_BIT];
            stat_r  <= i_conv_status;
            data_r  <= data_nxt;
        end
    end

    // Left-justified: data then status byte; append flag read live
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_result <= 32'h00000000;
        else if (ifc_r[aic_pkg::STATUS_APPEND_BIT]) begin
            if (short_r)
                o_result <= {data_r[23:8], stat_r, 8'h00};
            else
                o_result <= {data_r, stat_r};
        end else
            o_result <= {data_r, 8'h00};
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_result_len <= 6'h00;
        else
            o_result_len <= result_bits(short_r,
                ifc_r[aic_pkg::STATUS_APPEND_BIT]);
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_chk_mode <= aic_pkg::SER_IF_CTRL_RESET[aic_pkg::CHK_LSB +: 2];
        else
            o_chk_mode <= chk_field;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_chk_extra_byte <= 1'b0;
        else
            o_chk_extra_byte <= chk_adds_byte(chk_field);
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_bipolar <= aic_pkg::CONV_CFG_RESET[aic_pkg::OUTPUT_CODING_BIT];
        else
            o_bipolar <= cfg_r[aic_pkg::OUTPUT_CODING_BIT];
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_ref_buf <= aic_pkg::CONV_CFG_RESET[aic_pkg::REF_BUF_LSB +: 2];
        else
            o_ref_buf <= cfg_r[aic_pkg::REF_BUF_LSB +: 2];
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_in_buf <= aic_pkg::CONV_CFG_RESET[aic_pkg::INPUT_BUF_LSB +: 2];
        else
            o_in_buf <= cfg_r[aic_pkg::INPUT_BUF_LSB +: 2];
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_chan_en <= aic_pkg::CHAN_DEFAULT;
        else if (chan_field == 4'h0)
            o_chan_en <= aic_pkg::CHAN_DEFAULT;
        else
            o_chan_en <= chan_field;
    end
endmodule

/* File: tb/aic_regs_properties.sv */
/* Port assertions for the register bank.
   Assumes one clock, async active-low reset. */
`timescale 1ns/1ps
module aic_regs_chk (
    input wire logic        i_clock,
    input wire logic        i_arst_n,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic [5:0]  o_result_len,
    input wire logic [1:0]  o_chk_mode,
    input wire logic        o_chk_extra_byte,
    input wire logic        o_bipolar,
    input wire logic [1:0]  o_ref_buf,
    input wire logic [3:0]  o_chan_en
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    ifc_rsvd_a: assert property (i_rd && i_addr == 8'h02 |=> (o_rdata & 16'hffb2) == 16'h0000) else $error("ifc reserved bits set");
    cfg_rsvd_a: assert property (i_rd && i_addr == 8'h03 |=> (o_rdata & 16'he080) == 16'h0000) else $error("cfg reserved bits set");
    unmapped_read_a: assert property (i_rd && i_addr > 8'h03 |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
    chk_mode_a: assert property (i_wr && i_addr == 8'h02 |-> ##2 o_chk_mode == $past(i_wdata[3:2], 2)) else $error("checksum field wrong");
    extra_byte_a: assert property (o_chk_extra_byte == (o_chk_mode == 2'h1 || o_chk_mode == 2'h2)) else $error("extra byte wrong");
    coding_bit_a: assert property (i_wr && i_addr == 8'h03 |-> ##2 o_bipolar == $past(i_wdata[12], 2)) else $error("coding bit wrong");
    ref_buf_a: assert property (i_wr && i_addr == 8'h03 |-> ##2 o_ref_buf == $past(i_wdata[11:10], 2)) else $error("ref buffer wrong");
    chan_auto_a: assert property (o_chan_en != 4'h0) else $error("no channel enabled");
    len_legal_a: assert property (o_result_len inside {6'h00, 6'h10, 6'h18, 6'h20}) else $error("bad length");
endmodule
bind aic_regs aic_regs_chk chk (.*);

/* File: tb/aic_host.sv */
/* Host model issuing register accesses.
   Assumes the bank's clock; one access at a time. */
`timescale 1ns/1ps
module aic_host (
    input  wire logic        i_clock,
    input  wire logic [15:0] i_rdata,
    output logic             o_wr = 1'b0,
    output logic             o_rd = 1'b0,
    output logic [7:0]       o_addr = 8'h00,
    output logic [15:0]      o_wdata = 16'h0000
);
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_wdata <= ~d; // Released bus shows junk, never the old value
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

/* File: tb/aic_regs_tb_top.sv */
/* Self-checking bench for the register bank.
   Assumes aic_host drives the register port. */
`timescale 1ns/1ps
module aic_regs_tb_top;
    logic i_clock = 1'b0, i_arst_n = 1'b0, i_conv_done = 1'b0;
    logic i_result_rd = 1'b0, i_wr, i_rd, o_chk_extra_byte, o_bipolar;
    logic [23:0] i_conv_data = 24'h000000;
    logic [7:0]  i_conv_status = 8'h00, i_addr;
    logic [15:0] i_wdata, o_rdata, v;
    logic [31:0] o_result;
    logic [5:0]  o_result_len;
    logic [1:0]  o_chk_mode, o_ref_buf, o_in_buf;
    logic [3:0]  o_chan_en;
    int num_errors = 0, cmp_count = 0;
    always #5 i_clock = ~i_clock;
    aic_host host (.i_clock(i_clock), .i_rdata(o_rdata), .o_wr(i_wr),
        .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
    aic_regs uut (.*);
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    task automatic conv(input logic [23:0] d, input logic [7:0] s);
        @(posedge i_clock);
        i_conv_data <= d;
        i_conv_status <= s;
        i_conv_done <= 1'b1;
        @(posedge i_clock);
        i_conv_done <= 1'b0;
        settle();
    endtask
    task automatic t_reset;
        host.rd(8'h02, v); cmp(v, 32'h0);
        host.rd(8'h03, v); cmp(v, 32'h1340);
        cmp(o_chan_en, 32'h1);
        cmp({o_in_buf, o_bipolar, o_ref_buf}, 32'h1c);
        host.rd(8'h07, v); cmp(v, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_chk;
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h02, 16'(m << 2));
            settle();
            cmp(o_chk_mode, m);
            cmp(o_chk_extra_byte, (m == 1 || m == 2));
        end
        $display("checksum test done");
    endtask
    task automatic t_cfg;
        host.wr(8'h03, 16'hffff);
        host.rd(8'h03, v); cmp(v, 32'h1f7f);
        for (int r = 0; r < 4; r++) begin
            host.wr(8'h03, 16'(r << 10));
            settle();
            cmp({o_ref_buf, o_bipolar, o_chan_en}, (r << 5) | 1);
            cmp(o_in_buf, 32'h0);
        end
        $display("config test done");
    endtask
    task automatic t_result;
        host.wr(8'h02, 16'h0000);
        conv(24'h654321, 8'h11);
        cmp({o_result[31:8], o_result_len}, {24'h654321, 6'h18});
        host.wr(8'h02, 16'h0041);
        settle();
        cmp(o_result[31:16], 32'h6543);
        conv(24'h123480, 8'ha5);
        cmp({o_result[31:8], o_result_len}, {24'h1235a5, 6'h18});
        host.wr(8'h02, 16'h0040);
        conv(24'habcdef, 8'h3c);
        cmp({o_result, o_result_len}, {32'habcdef3c, 6'h20});
        $display("result test done");
    endtask
    task automatic t_short;
        host.wr(8'h02, 16'h0001);
        conv(24'hffff90, 8'h5a);
        cmp(o_result, 32'hffff0000);
        cmp(o_result_len, 32'h10);
        @(posedge i_clock);
        i_result_rd <= 1'b1;
        conv(24'h000001, 8'h77);
        cmp(o_result, 32'hffff0000);
        @(posedge i_clock);
        i_result_rd <= 1'b0;
        host.wr(8'h05, 16'hffff);
        host.rd(8'h02, v);
        cmp(v, 32'h1);
        $display("short test done");
    endtask
    task automatic t_midreset;
        @(posedge i_clock);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_arst_n <= 1'b1;
        cmp(o_result, 32'h0);
        t_reset();
        $display("mid reset test done");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_arst_n <= 1'b1;
        t_reset();
        t_chk();
        t_cfg();
        t_result();
        t_short();
        t_midreset();
        tally_and_finish();
    end
    initial begin
        #20us;
        num_errors++;
        tally_and_finish();
    end
endmodule
